// file: mmc_pkg.sv
// Purpose: shared constants and types for the module management control block
// Assumes: system clock of 125 MHz, link clock free running and faster than 4x SCL
// Notes: two-wire byte offsets follow the lower management page layout
package mmc_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned CLK_MHZ = CLK_KHZ / 1000;
  localparam int unsigned T_INIT_MS = 2000;
  localparam int unsigned T_RESET_MIN_US = 2;
  localparam int unsigned INIT_CYC = T_INIT_MS * CLK_KHZ;
  localparam int unsigned RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;
  localparam int unsigned INIT_CNT_W = 28;
  localparam int unsigned RESET_CNT_W = 9;

  // ----------------------------------------------------------------
  // two-wire bus map
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] REG_IDENT = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_FLAGS = 8'h03;
  localparam logic [7:0] REG_CTRL = 8'h5D;
  localparam logic [7:0] REG_MASK = 8'h64;
  localparam int unsigned STATUS_NOT_READY_BIT = 0;
  localparam int unsigned CTRL_PDOWN_BIT = 0;
  localparam int unsigned FLAG_INIT_BIT = 0;
  localparam int unsigned FLAG_LOS_BIT = 1;
  localparam int unsigned NUM_FAULT = 6;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_WR = 3'b011,
    ST_ACK_WR = 3'b100,
    ST_RD = 3'b101,
    ST_ACK_RD = 3'b110
  } mmc_link_state_e;

  typedef struct packed {
    logic in_reset;
    logic not_ready;
    logic [7:0] flags;
  } mmc_stat_s;

  typedef struct packed {
    logic power_down;
    logic [7:0] mask;
  } mmc_ctrl_s;

endpackage

// file: mmc_sync.sv
// Purpose: two flip-flop synchroniser for levels entering a clock domain
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module mmc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= RESET_VALUE;
      q <= RESET_VALUE;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // mmc_sync

// file: mmc_top.sv
// Purpose: module control and status logic behind the management pins
// Assumes: link clock oversamples the two-wire bus; SCL is input only
// Notes: bus engine on the link clock, flags and power state on sys_clk
`timescale 1ns/1ps
module mmc_top #(
  parameter int unsigned INIT_CYC = mmc_pkg::INIT_CYC,
  parameter logic [7:0] IDENT_CODE = 8'h5A // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mgmt_link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic module_select_n_input,
  input wire logic module_reset_n_input,
  input wire logic low_power_request_input,
  input wire logic rx_los_input,
  input wire logic [mmc_pkg::NUM_FAULT-1:0] fault_input,
  input wire logic monitor_valid_input,
  output logic interrupt_n_output,
  output logic low_power_output
);
  import mmc_pkg::*;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic link_rst;
  logic [2:0] link_pins;
  mmc_stat_s stat_sys;
  mmc_stat_s stat_link;
  mmc_ctrl_s ctrl_link;
  mmc_ctrl_s ctrl_sys;
  logic [NUM_FAULT+2:0] pins_sys;
  logic clr_req;
  logic clr_req_sys;
  logic clr_seen;
  logic clr_ack_link;
  logic [7:0] clr_data;

  mmc_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_link_rst (
    .clk(mgmt_link_clk),
    .rst(1'b0),
    .d(sys_rst),
    .q(link_rst)
  );

  mmc_sync #(.WIDTH(3), .RESET_VALUE(3'h7)) u_link_pins (
    .clk(mgmt_link_clk),
    .rst(link_rst),
    .d({scl_in, sda_in, module_select_n_input}),
    .q(link_pins)
  );

  mmc_sync #(.WIDTH(10), .RESET_VALUE(10'h300)) u_stat (
    .clk(mgmt_link_clk),
    .rst(link_rst),
    .d(stat_sys),
    .q(stat_link)
  );

  mmc_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) u_clr_ack (
    .clk(mgmt_link_clk),
    .rst(link_rst),
    .d(clr_seen),
    .q(clr_ack_link)
  );

  mmc_sync #(.WIDTH(9), .RESET_VALUE(9'h000)) u_ctrl (
    .clk(sys_clk),
    .rst(sys_rst),
    .d(ctrl_link),
    .q(ctrl_sys)
  );

  mmc_sync #(.WIDTH(NUM_FAULT + 3), .RESET_VALUE(9'h100)) u_pins (
    .clk(sys_clk),
    .rst(sys_rst),
    .d({module_reset_n_input, low_power_request_input, rx_los_input, fault_input}),
    .q(pins_sys)
  );

  mmc_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) u_clr_req (
    .clk(sys_clk),
    .rst(sys_rst),
    .d(clr_req),
    .q(clr_req_sys)
  );

  // ----------------------------------------------------------------
  // link domain: bus condition detect
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic sel_n_s;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic link_hold;

  assign scl_s = link_pins[2];
  assign sda_s = link_pins[1];
  assign sel_n_s = link_pins[0];

  always_ff @(posedge mgmt_link_clk)
  begin
    if (link_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
  // deselected or held in module reset: bus is ignored
  assign link_hold = sel_n_s | stat_link.in_reset;

  // ----------------------------------------------------------------
  // link domain: two-wire engine
  // ----------------------------------------------------------------
  mmc_link_state_e st;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic ptr_set;
  logic is_read;
  logic nack;
  logic [7:0] rd_byte;
  logic load_fire;
  logic wr_fire;

  always_comb
  begin
    unique case (ptr)
      REG_IDENT: rd_byte = IDENT_CODE;
      REG_STATUS: rd_byte = 8'(stat_link.not_ready) << STATUS_NOT_READY_BIT;
      REG_FLAGS: rd_byte = stat_link.flags;
      REG_CTRL: rd_byte = 8'(ctrl_link.power_down) << CTRL_PDOWN_BIT;
      REG_MASK: rd_byte = ctrl_link.mask;
      default: rd_byte = 8'h00;
    endcase
  end

  assign load_fire = !link_hold && scl_fall
    && ((st == ST_ACK_ADDR && is_read) || (st == ST_ACK_RD && !nack));
  assign wr_fire = !link_hold && scl_fall && st == ST_WR && cnt == 4'h8 && ptr_set;

  always_ff @(posedge mgmt_link_clk)
  begin
    if (link_rst)
    begin
      st <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      ptr_set <= 1'b0;
      is_read <= 1'b0;
      nack <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (link_hold || stop_det)
    begin
      st <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end
    else if (start_det)
    begin
      st <= ST_ADDR;
      cnt <= 4'h0;
      ptr_set <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (load_fire)
    begin
      shift <= {rd_byte[6:0], 1'b0};
      sda_oe_n <= rd_byte[7];
      cnt <= 4'h0;
      ptr <= ptr + 8'h01;
      st <= ST_RD;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
        begin
          sda_oe_n <= 1'b1;
        end
        ST_ADDR, ST_WR:
        begin
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          else if (scl_fall && cnt == 4'h8)
          begin
            if (st == ST_WR)
            begin
              sda_oe_n <= 1'b0;
              st <= ST_ACK_WR;
              ptr_set <= 1'b1;
              ptr <= ptr_set ? ptr + 8'h01 : shift;
            end
            else if (shift[7:1] == DEV_ADDR)
            begin
              sda_oe_n <= 1'b0;
              is_read <= shift[0];
              st <= ST_ACK_ADDR;
            end
            else
            begin
              st <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR:
        begin
          if (scl_fall)
          begin
            sda_oe_n <= 1'b1;
            cnt <= 4'h0;
            st <= ST_WR;
          end
        end
        ST_RD:
        begin
          if (scl_rise)
          begin
            cnt <= cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt == 4'h8)
            begin
              sda_oe_n <= 1'b1;
              st <= ST_ACK_RD;
            end
            else
            begin
              sda_oe_n <= shift[7];
              shift <= {shift[6:0], 1'b0};
            end
          end
        end
        ST_ACK_RD:
        begin
          if (scl_rise)
          begin
            nack <= sda_s;
          end
          else if (scl_fall)
          begin
            st <= ST_IDLE;
          end
        end
        default:
        begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mgmt_link_clk)
  begin
    sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // link domain: writable control bytes
  // ----------------------------------------------------------------
  always_ff @(posedge mgmt_link_clk)
  begin
    if (link_rst || stat_link.in_reset)
    begin
      ctrl_link.mask <= MASK_RST;
      ctrl_link.power_down <= 1'b0;
    end
    else if (wr_fire)
    begin
      if (ptr == REG_MASK)
      begin
        ctrl_link.mask <= shift;
      end
      if (ptr == REG_CTRL)
      begin
        ctrl_link.power_down <= shift[CTRL_PDOWN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain: clear-on-read handshake
  // ----------------------------------------------------------------
  logic [7:0] rd_seen;
  logic [7:0] pend;
  logic [7:0] next_pend;

  // reads only take effect once the stop closes the transfer
  assign next_pend = pend | (stop_det ? rd_seen : 8'h00);

  always_ff @(posedge mgmt_link_clk)
  begin
    if (link_rst)
    begin
      rd_seen <= 8'h00;
      pend <= 8'h00;
      clr_data <= 8'h00;
      clr_req <= 1'b0;
    end
    else
    begin
      if (stop_det || link_hold)
      begin
        rd_seen <= 8'h00;
      end
      else if (load_fire && ptr == REG_FLAGS)
      begin
        rd_seen <= rd_seen | stat_link.flags;
      end
      if (clr_req == clr_ack_link && next_pend != 8'h00)
      begin
        clr_data <= next_pend;
        pend <= 8'h00;
        clr_req <= ~clr_req;
      end
      else
      begin
        pend <= next_pend;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain: reset pin filter and initialisation
  // ----------------------------------------------------------------
  logic [RESET_CNT_W-1:0] rlow_cnt;
  logic [INIT_CNT_W-1:0] init_cnt;
  logic nr_q;
  logic mod_in_reset;
  logic not_ready;
  logic [7:0] flags;

  // one writer per field, gathered for the crossing
  assign stat_sys = {mod_in_reset, not_ready, flags};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || pins_sys[NUM_FAULT+2])
    begin
      rlow_cnt <= '0;
      mod_in_reset <= 1'b0;
    end
    else if (rlow_cnt != RESET_CNT_W'(RESET_MIN_CYC))
    begin
      rlow_cnt <= rlow_cnt + RESET_CNT_W'(1);
    end
    else
    begin
      mod_in_reset <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || stat_sys.in_reset)
    begin
      init_cnt <= '0;
      not_ready <= 1'b1;
    end
    else if (stat_sys.not_ready)
    begin
      init_cnt <= init_cnt + INIT_CNT_W'(1);
      if (monitor_valid_input || init_cnt == INIT_CNT_W'(INIT_CYC - 1))
      begin
        not_ready <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain: flags and interrupt
  // ----------------------------------------------------------------
  logic [NUM_FAULT:0] cond_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cond_q <= '0;
      nr_q <= 1'b1;
      clr_seen <= 1'b0;
    end
    else
    begin
      cond_q <= pins_sys[NUM_FAULT:0];
      nr_q <= stat_sys.not_ready;
      clr_seen <= clr_req_sys;
    end
  end

  assign flag_set = {pins_sys[NUM_FAULT-1:0] & ~cond_q[NUM_FAULT-1:0],
                     pins_sys[NUM_FAULT] & ~cond_q[NUM_FAULT],
                     nr_q & ~stat_sys.not_ready};
  // clr_data is steady while the request toggle is in flight
  assign flag_clr = (clr_req_sys != clr_seen) ? clr_data : 8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || stat_sys.in_reset)
    begin
      flags <= FLAGS_RST;
    end
    else
    begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      interrupt_n_output <= 1'b1;
    end
    else
    begin
      interrupt_n_output <= ~|(stat_sys.flags & ~ctrl_sys.mask);
    end
  end

  // ----------------------------------------------------------------
  // system domain: power level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      low_power_output <= 1'b0;
    end
    else
    begin
      low_power_output <= pins_sys[NUM_FAULT+1] | ctrl_sys.power_down;
    end
  end

endmodule // mmc_top

// file: mmc_top_properties.sv
// Purpose: port checks for the management control block
// Assumes: sys_rst clears both clock domains
// Notes: bound to every mmc_top instance
`timescale 1ns/1ps
module mmc_top_properties
  import mmc_pkg::*;
#(
  parameter int unsigned INIT_CYC = mmc_pkg::INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mgmt_link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic module_select_n_input,
  input wire logic module_reset_n_input,
  input wire logic low_power_request_input,
  input wire logic rx_los_input,
  input wire logic [mmc_pkg::NUM_FAULT-1:0] fault_input,
  input wire logic monitor_valid_input,
  input wire logic interrupt_n_output,
  input wire logic low_power_output
);
  int unsigned init_cnt;
  int unsigned low_cnt;
  logic valid_seen;
  logic long_rst;

  assign long_rst = (low_cnt > RESET_MIN_CYC + 8);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || module_reset_n_input)
      low_cnt <= 0;
    else if (!long_rst)
      low_cnt <= low_cnt + 1;
  end

  // cycles since the last full reset ended, held once it reaches INIT_CYC + 20
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || long_rst)
      init_cnt <= 0;
    else if (init_cnt < INIT_CYC + 20)
      init_cnt <= init_cnt + 1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || long_rst)
      valid_seen <= monitor_valid_input;
    else if (monitor_valid_input)
      valid_seen <= 1'b1;
  end

  property p_rst_quiet;
    @(posedge sys_clk) sys_rst |=> interrupt_n_output && !low_power_output;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active output in reset");

  property p_lp_follow;
    @(posedge sys_clk) disable iff (sys_rst) low_power_request_input [*5] |-> low_power_output;
  endproperty
  a_lp_follow: assert property (p_lp_follow) else $error("low power not entered");

  property p_init_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !valid_seen && init_cnt < INIT_CYC |-> interrupt_n_output;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("ready reported too early");

  property p_init_done;
    @(posedge sys_clk) disable iff (sys_rst) init_cnt == INIT_CYC + 16 |-> !interrupt_n_output;
  endproperty
  a_init_done: assert property (p_init_done) else $error("ready not reported in time");

  property p_mod_reset_int;
    @(posedge sys_clk) disable iff (sys_rst) long_rst |-> interrupt_n_output;
  endproperty
  a_mod_reset_int: assert property (p_mod_reset_int) else $error("interrupt in reset");

  property p_mod_reset_bus;
    @(posedge sys_clk) disable iff (sys_rst) long_rst |-> sda_oe_n;
  endproperty
  a_mod_reset_bus: assert property (p_mod_reset_bus) else $error("bus driven in reset");

  property p_desel_quiet;
    @(posedge mgmt_link_clk) disable iff (sys_rst) module_select_n_input [*6] |-> sda_oe_n;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("bus driven unselected");

  property p_sda_on_low;
    @(posedge mgmt_link_clk) disable iff (sys_rst)
      $changed(sda_oe_n) |-> !scl_in || module_select_n_input || !module_reset_n_input;
  endproperty
  a_sda_on_low: assert property (p_sda_on_low) else $error("data moved with clock high");

  property p_sda_open_drain;
    @(posedge mgmt_link_clk) disable iff (sys_rst) !sda_out;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain) else $error("data pin driven high");

  c_ack: cover property (@(posedge mgmt_link_clk) disable iff (sys_rst) $fell(sda_oe_n));
  c_int: cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(interrupt_n_output));
  c_lp: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(low_power_output));
  c_mrst: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(long_rst));
endmodule // mmc_top_properties

bind mmc_top mmc_top_properties #(.INIT_CYC(INIT_CYC)) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .mgmt_link_clk(mgmt_link_clk), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .module_select_n_input(module_select_n_input), .module_reset_n_input(module_reset_n_input),
  .low_power_request_input(low_power_request_input), .rx_los_input(rx_los_input),
  .fault_input(fault_input), .monitor_valid_input(monitor_valid_input),
  .interrupt_n_output(interrupt_n_output), .low_power_output(low_power_output)
);

// file: mmc_host_model.sv
// Purpose: two-wire bus host facing the management control block
// Assumes: data line pulled up; clock line driven by this host alone
// Notes: bus timing counted in sys_clk cycles
`timescale 1ns/1ps
module mmc_host_model #(
  parameter int unsigned HALF = 10
) (
  input wire logic sys_clk,
  input wire logic sda_oe_n,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic host_sda;

  initial
  begin
    scl = 1'b1;
    host_sda = 1'b1;
  end

  // wired-and with pull-up
  assign sda = host_sda & (sda_oe_n | sda_out);

  task automatic wait_cyc(input int unsigned n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic start_cond;
    @(posedge sys_clk);
    host_sda <= 1'b1;
    wait_cyc(HALF);
    scl <= 1'b1;
    wait_cyc(HALF);
    host_sda <= 1'b0;
    wait_cyc(HALF);
    scl <= 1'b0;
    wait_cyc(3);
  endtask

  task automatic stop_cond;
    host_sda <= 1'b0;
    wait_cyc(HALF);
    scl <= 1'b1;
    wait_cyc(HALF);
    host_sda <= 1'b1;
    wait_cyc(HALF);
  endtask

  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    host_sda <= b;
    wait_cyc(HALF);
    scl <= 1'b1;
    wait_cyc(HALF);
    r = sda;
    scl <= 1'b0;
    wait_cyc(3);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic a_out, output logic [7:0] q,
                       output logic a_in);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a_out, a_in);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic [2:0] a;
    start_cond();
    xbyte({dev, 1'b0}, 1'b1, q, a[0]);
    xbyte(ptr, 1'b1, q, a[1]);
    xbyte(data, 1'b1, q, a[2]);
    stop_cond();
    ok = (a === 3'b000);
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic [3:0] a;
    start_cond();
    xbyte({dev, 1'b0}, 1'b1, q, a[0]);
    xbyte(ptr, 1'b1, q, a[1]);
    start_cond();
    xbyte({dev, 1'b1}, 1'b1, q, a[2]);
    xbyte(8'hFF, 1'b1, data, a[3]);
    stop_cond();
    ok = (a[2:0] === 3'b000);
  endtask
endmodule // mmc_host_model

// file: test_mmc_top.sv
// Purpose: directed test of the management control block
// Assumes: host model drives the two-wire bus
// Notes: init count shortened to keep the run brief
`timescale 1ns/1ps
module test_mmc_top;
  import mmc_pkg::*;
  localparam int unsigned INIT_CYCLES = 3000;
  localparam logic [7:0] IDENT = 8'h3C; // arbitrary value
  logic sys_clk, sys_rst, mgmt_link_clk, scl, sda, sda_out, sda_oe_n;
  logic module_select_n_input, module_reset_n_input, low_power_request_input;
  logic rx_los_input, monitor_valid_input, interrupt_n_output, low_power_output;
  logic [NUM_FAULT-1:0] fault_input;
  logic [7:0] rd_data;
  logic ack_ok;
  int mismatches;
  int cmp_count;

  mmc_top #(.INIT_CYC(INIT_CYCLES), .IDENT_CODE(IDENT)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .mgmt_link_clk(mgmt_link_clk), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .module_select_n_input(module_select_n_input), .module_reset_n_input(module_reset_n_input),
    .low_power_request_input(low_power_request_input), .rx_los_input(rx_los_input),
    .fault_input(fault_input), .monitor_valid_input(monitor_valid_input),
    .interrupt_n_output(interrupt_n_output), .low_power_output(low_power_output)
  );
  mmc_host_model u_host (.sys_clk(sys_clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl(scl),
    .sda(sda));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    mgmt_link_clk = 1'b0;
    #2.7;
    forever #6 mgmt_link_clk = ~mgmt_link_clk;
  end

  task automatic check_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd_check(input string name, input logic [7:0] ptr, input logic [7:0] exp);
    u_host.read_reg(DEV_ADDR, ptr, rd_data, ack_ok);
    check_bit("read ack", 1'b1, ack_ok);
    check_byte(name, exp, rd_data);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    u_host.write_reg(DEV_ADDR, ptr, data, ack_ok);
    check_bit("write ack", 1'b1, ack_ok);
  endtask
  // let clocked outputs land before looking
  task automatic settle(input int unsigned n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    module_select_n_input = 1'b0;
    module_reset_n_input = 1'b1;
    low_power_request_input = 1'b0;
    rx_los_input = 1'b0;
    fault_input = '0;
    monitor_valid_input = 1'b0;
    settle(15);
    check_bit("int in reset", 1'b1, interrupt_n_output);
    @(posedge sys_clk) sys_rst <= 1'b0;
    settle(10);
    rd_check("status early", REG_STATUS, 8'h01);
    check_bit("int before ready", 1'b1, interrupt_n_output);
    settle(INIT_CYCLES);
    check_bit("int at ready", 1'b0, interrupt_n_output);
    rd_check("status ready", REG_STATUS, 8'h00);
    rd_check("init flag", REG_FLAGS, 8'h01);
    settle(8);
    check_bit("int released", 1'b1, interrupt_n_output);
    rd_check("ident", REG_IDENT, IDENT);
    u_host.read_reg(7'h51, REG_IDENT, rd_data, ack_ok);
    check_bit("foreign address ack", 1'b0, ack_ok);
    @(posedge sys_clk) rx_los_input <= 1'b1;
    settle(8);
    check_bit("int on los", 1'b0, interrupt_n_output);
    rd_check("los flag", REG_FLAGS, 8'h02);
    settle(8);
    check_bit("int after los read", 1'b1, interrupt_n_output);
    @(posedge sys_clk) rx_los_input <= 1'b0;
    for (int i = 0; i < NUM_FAULT; i++)
    begin
      @(posedge sys_clk) fault_input <= 6'h01 << i;
      settle(8);
      check_bit("int on fault", 1'b0, interrupt_n_output);
      rd_check("fault flag", REG_FLAGS, 8'h04 << i);
      settle(8);
      check_bit("int after fault read", 1'b1, interrupt_n_output);
      @(posedge sys_clk) fault_input <= '0;
    end
    wr(REG_MASK, 8'h04);
    @(posedge sys_clk) fault_input <= 6'h01;
    settle(8);
    check_bit("int masked", 1'b1, interrupt_n_output);
    wr(REG_MASK, 8'h00);
    settle(8);
    check_bit("int unmasked", 1'b0, interrupt_n_output);
    @(posedge sys_clk) fault_input <= '0;
    rd_check("masked flag", REG_FLAGS, 8'h04);
    settle(8);
    check_bit("int after unmask read", 1'b1, interrupt_n_output);
    wr(REG_CTRL, 8'h01);
    settle(8);
    check_bit("power down", 1'b1, low_power_output);
    rd_check("ctrl", REG_CTRL, 8'h01);
    wr(REG_CTRL, 8'h00);
    settle(8);
    check_bit("power up", 1'b0, low_power_output);
    @(posedge sys_clk) low_power_request_input <= 1'b1;
    settle(6);
    check_bit("lp pin high", 1'b1, low_power_output);
    @(posedge sys_clk) low_power_request_input <= 1'b0;
    settle(6);
    check_bit("lp pin low", 1'b0, low_power_output);
    @(posedge sys_clk) module_select_n_input <= 1'b1;
    settle(8);
    u_host.read_reg(DEV_ADDR, REG_IDENT, rd_data, ack_ok);
    check_bit("deselected ack", 1'b0, ack_ok);
    @(posedge sys_clk) module_select_n_input <= 1'b0;
    settle(8);
    rd_check("ident reselected", REG_IDENT, IDENT);
    wr(REG_MASK, 8'hFF);
    @(posedge sys_clk) module_reset_n_input <= 1'b0;
    settle(100);
    @(posedge sys_clk) module_reset_n_input <= 1'b1;
    settle(8);
    rd_check("mask after glitch", REG_MASK, 8'hFF);
    @(posedge sys_clk) module_reset_n_input <= 1'b0;
    settle(300);
    check_bit("int in module reset", 1'b1, interrupt_n_output);
    @(posedge sys_clk) module_reset_n_input <= 1'b1;
    settle(10);
    rd_check("mask after reset", REG_MASK, 8'h00);
    rd_check("status after reset", REG_STATUS, 8'h01);
    check_bit("int not ready", 1'b1, interrupt_n_output);
    @(posedge sys_clk) monitor_valid_input <= 1'b1;
    settle(8);
    check_bit("int monitor valid", 1'b0, interrupt_n_output);
    rd_check("status valid", REG_STATUS, 8'h00);
    check_bit("data pin output", 1'b0, sda_out);
    end_of_test();
  end
endmodule // test_mmc_top
